// *** core/out_term_pkg.sv ***
// Package: register map, function codes and timing constants for the output terminal mux.
package out_term_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on APB)
	// ------------------------------------------------------------
	localparam logic [7:0] DIGITAL_OUT_ONE_FUNCTION_ADDR       = 8'h00;
	localparam logic [7:0] MAIN_RELAY_FUNCTION_ADDR            = 8'h04;
	localparam logic [7:0] SECOND_RELAY_FUNCTION_ADDR          = 8'h08;
	localparam logic [7:0] RESERVED_OUTPUT_SLOT_ADDR           = 8'h0c;
	localparam logic [7:0] OPEN_COLLECTOR_SWITCH_FUNCTION_ADDR = 8'h10;
	localparam logic [7:0] COMM_VALUE_ADDR                     = 8'h14;
	localparam logic [7:0] TERMINAL_STATUS_ADDR                = 8'h18;

	// ------------------------------------------------------------
	// Reset values and field layout
	// ------------------------------------------------------------
	localparam int          CODE_W             = 8;
	localparam int          NUM_TERMS          = 4;
	localparam logic [7:0]  DIGITAL_OUT_RESET  = 8'h01;
	localparam logic [7:0]  MAIN_RELAY_RESET   = 8'h02;
	localparam logic [7:0]  SECOND_RELAY_RESET = 8'h00;
	localparam logic [7:0]  OPEN_COLL_RESET    = 8'h00;
	localparam int          TERM_DOUT_BIT      = 0;
	localparam int          TERM_RELAY1_BIT    = 1;
	localparam int          TERM_RELAY2_BIT    = 2;
	localparam int          TERM_OCSW_BIT      = 3;

	// ------------------------------------------------------------
	// Function codes
	// ------------------------------------------------------------
	localparam logic [7:0] FN_NONE          = 8'h00;
	localparam logic [7:0] FN_RUNNING       = 8'h01;
	localparam logic [7:0] FN_FAULT_STOP    = 8'h02;
	localparam logic [7:0] FN_ZERO_RUN      = 8'h05;
	localparam logic [7:0] FN_MOTOR_OL_PRE  = 8'h06;
	localparam logic [7:0] FN_DRIVE_OL_PRE  = 8'h07;
	localparam logic [7:0] FN_SET_COUNT     = 8'h08;
	localparam logic [7:0] FN_DESIG_COUNT   = 8'h09;
	localparam logic [7:0] FN_LENGTH        = 8'h0a;
	localparam logic [7:0] FN_SEQ_CYCLE     = 8'h0b;
	localparam logic [7:0] FN_RUN_TIME      = 8'h0c;
	localparam logic [7:0] FN_FREQ_LIMITED  = 8'h0d;
	localparam logic [7:0] FN_TORQUE_LIMIT  = 8'h0e;
	localparam logic [7:0] FN_READY         = 8'h0f;
	localparam logic [7:0] FN_ANALOG_CMP    = 8'h10;
	localparam logic [7:0] FN_UPPER_LIMIT   = 8'h11;
	localparam logic [7:0] FN_LOWER_RUN     = 8'h12;
	localparam logic [7:0] FN_UNDERVOLTAGE  = 8'h13;
	localparam logic [7:0] FN_COMM          = 8'h14;
	localparam logic [7:0] FN_ZERO_ANY      = 8'h17;
	localparam logic [7:0] FN_POWER_ON_TIME = 8'h18;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ          = 200_000_000;
	localparam int SEQ_PULSE_MS    = 250;
	localparam int SEQ_PULSE_CYCLES = CLK_HZ / 1000 * SEQ_PULSE_MS;
	localparam int PULSE_CNT_W     = 26;

	// ------------------------------------------------------------
	// Drive status carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic running;
		logic fault_stopped;
		logic out_freq_zero;
		logic motor_ol_prealarm;
		logic drive_ol_prealarm;
		logic set_count_reached;
		logic desig_count_reached;
		logic length_reached;
		logic seq_cycle_done;
		logic run_time_reached;
		logic set_freq_beyond_limit;
		logic at_upper_limit;
		logic at_lower_limit;
		logic torque_at_limit;
		logic stall_active;
		logic power_stable;
		logic fault_detected;
		logic operable;
		logic undervoltage;
		logic power_on_time_reached;
	} drive_status_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

// *** core/term_select.sv ***
// Module: combinational selection of one terminal's condition from its function code.
`timescale 1ns/1ps
module term_select (
	// Selection
	input  wire logic [7:0]                  code_in,
	// Conditions
	input  wire out_term_pkg::drive_status_t status_in,
	input  wire logic                        analog_gt_in,
	input  wire logic                        seq_pulse_in,
	input  wire logic                        comm_bit_in,
	// Result
	output logic                             level_out
);
	import out_term_pkg::*;

	always_comb begin
		case (code_in)
			FN_NONE:          level_out = 1'b0;
			FN_RUNNING:       level_out = status_in.running;
			FN_FAULT_STOP:    level_out = status_in.fault_stopped;
			FN_ZERO_RUN:      level_out = status_in.running & status_in.out_freq_zero;
			FN_MOTOR_OL_PRE:  level_out = status_in.motor_ol_prealarm;
			FN_DRIVE_OL_PRE:  level_out = status_in.drive_ol_prealarm;
			FN_SET_COUNT:     level_out = status_in.set_count_reached;
			FN_DESIG_COUNT:   level_out = status_in.desig_count_reached;
			FN_LENGTH:        level_out = status_in.length_reached;
			FN_SEQ_CYCLE:     level_out = seq_pulse_in;
			FN_RUN_TIME:      level_out = status_in.run_time_reached;
			FN_FREQ_LIMITED:  level_out = status_in.set_freq_beyond_limit
				& (status_in.at_upper_limit | status_in.at_lower_limit);
			FN_TORQUE_LIMIT:  level_out = status_in.torque_at_limit
				& status_in.stall_active;
			FN_READY:         level_out = status_in.power_stable
				& ~status_in.fault_detected & status_in.operable;
			FN_ANALOG_CMP:    level_out = analog_gt_in;
			FN_UPPER_LIMIT:   level_out = status_in.running & status_in.at_upper_limit;
			FN_LOWER_RUN:     level_out = status_in.running & status_in.at_lower_limit;
			FN_UNDERVOLTAGE:  level_out = status_in.undervoltage;
			FN_COMM:          level_out = comm_bit_in;
			FN_ZERO_ANY:      level_out = status_in.out_freq_zero
				| ~status_in.running;
			FN_POWER_ON_TIME: level_out = status_in.power_on_time_reached;
			default:          level_out = 1'b0;
		endcase
	end

endmodule

// *** core/output_terminal_function_mux.sv ***
// Module: APB-programmed function mux for the four switched output terminals.
`timescale 1ns/1ps
module output_terminal_function_mux #(
	parameter int ANALOG_W     = 12,
	parameter int PULSE_CYCLES = out_term_pkg::SEQ_PULSE_CYCLES
) (
	// Clock and reset
	input  wire logic                        sys_clk_in,
	input  wire logic                        rst_in,
	// APB slave
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [7:0]                  paddr_in,
	input  wire logic [31:0]                 pwdata_in,
	output logic [31:0]                      prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	// Drive status from the controller
	input  wire out_term_pkg::drive_status_t status_in,
	input  wire logic [ANALOG_W-1:0]         analog_input_one_in,
	input  wire logic [ANALOG_W-1:0]         analog_input_two_in,
	// Terminals
	output logic                             digital_output_one_out,
	output logic                             main_relay_contacts_out,
	output logic                             second_relay_out,
	output logic                             open_collector_switch_output_out
);
	import out_term_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [CODE_W-1:0]      sel_ff [NUM_TERMS];
	logic [CODE_W-1:0]      nxt_sel [NUM_TERMS];
	logic [NUM_TERMS-1:0]   comm_ff;
	logic [NUM_TERMS-1:0]   nxt_comm;
	logic [31:0]            prdata_ff;
	logic [31:0]            nxt_prdata;
	logic                   pready_ff;
	logic                   nxt_pready;
	logic                   pslverr_ff;
	logic                   nxt_pslverr;
	logic [NUM_TERMS-1:0]   term_ff;
	logic [NUM_TERMS-1:0]   nxt_term;
	logic [NUM_TERMS-1:0]   term_level;
	logic                   seq_done_d_ff;
	logic                   nxt_seq_done_d;
	logic [PULSE_CNT_W-1:0] pulse_cnt_ff;
	logic [PULSE_CNT_W-1:0] nxt_pulse_cnt;
	logic                   analog_gt;
	logic                   access;

	// Index of the selector register at an address, or NUM_TERMS when none.
	function automatic int sel_index(input logic [7:0] addr);
		case (addr)
			DIGITAL_OUT_ONE_FUNCTION_ADDR:       sel_index = TERM_DOUT_BIT;
			MAIN_RELAY_FUNCTION_ADDR:            sel_index = TERM_RELAY1_BIT;
			SECOND_RELAY_FUNCTION_ADDR:          sel_index = TERM_RELAY2_BIT;
			OPEN_COLLECTOR_SWITCH_FUNCTION_ADDR: sel_index = TERM_OCSW_BIT;
			default:                             sel_index = NUM_TERMS;
		endcase
	endfunction

	// ------------------------------------------------------------
	// APB register file
	// ------------------------------------------------------------
	// Every access is taken in its first access cycle; pready is registered, so the
	// answer appears one cycle after that access cycle, a single wait state.
	assign access = psel_in & penable_in & ~pready_ff;

	always_comb begin
		int idx;
		idx = sel_index(paddr_in);
		for (int i = 0; i < NUM_TERMS; i++) begin
			nxt_sel[i] = sel_ff[i];
		end
		nxt_comm    = comm_ff;
		nxt_prdata  = prdata_ff;
		nxt_pready  = access;
		nxt_pslverr = 1'b0;
		if (rst_in) begin
			nxt_sel[TERM_DOUT_BIT]   = DIGITAL_OUT_RESET;
			nxt_sel[TERM_RELAY1_BIT] = MAIN_RELAY_RESET;
			nxt_sel[TERM_RELAY2_BIT] = SECOND_RELAY_RESET;
			nxt_sel[TERM_OCSW_BIT]   = OPEN_COLL_RESET;
			nxt_comm    = '0;
			nxt_prdata  = '0;
			nxt_pready  = 1'b0;
		end else if (access) begin
			nxt_prdata = '0;
			if (idx < NUM_TERMS) begin
				if (pwrite_in) begin
					nxt_sel[idx] = pwdata_in[CODE_W-1:0];
				end else begin
					nxt_prdata[CODE_W-1:0] = sel_ff[idx];
				end
			end else if (paddr_in == COMM_VALUE_ADDR) begin
				if (pwrite_in) begin
					nxt_comm = pwdata_in[NUM_TERMS-1:0];
				end else begin
					nxt_prdata[NUM_TERMS-1:0] = comm_ff;
				end
			end else if (paddr_in == TERMINAL_STATUS_ADDR) begin
				nxt_pslverr = pwrite_in;
				nxt_prdata[NUM_TERMS-1:0] = term_ff;
			end else if (paddr_in != RESERVED_OUTPUT_SLOT_ADDR) begin
				// The reserved slot reads zero and ignores writes without an error.
				nxt_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		for (int i = 0; i < NUM_TERMS; i++) begin
			sel_ff[i] <= nxt_sel[i];
		end
		comm_ff    <= nxt_comm;
		prdata_ff  <= nxt_prdata;
		pready_ff  <= nxt_pready;
		pslverr_ff <= nxt_pslverr;
	end

	// ------------------------------------------------------------
	// Sequencer cycle pulse
	// ------------------------------------------------------------
	// A new cycle completion during a running pulse restarts the full width, so a
	// short sequencer cycle cannot produce a truncated pulse.
	always_comb begin
		nxt_seq_done_d = status_in.seq_cycle_done;
		nxt_pulse_cnt  = pulse_cnt_ff;
		if (rst_in) begin
			nxt_seq_done_d = 1'b0;
			nxt_pulse_cnt  = '0;
		end else if (status_in.seq_cycle_done & ~seq_done_d_ff) begin
			nxt_pulse_cnt = PULSE_CNT_W'(PULSE_CYCLES);
		end else if (pulse_cnt_ff != '0) begin
			nxt_pulse_cnt = pulse_cnt_ff - PULSE_CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		seq_done_d_ff <= nxt_seq_done_d;
		pulse_cnt_ff  <= nxt_pulse_cnt;
	end

	// ------------------------------------------------------------
	// Terminal selection
	// ------------------------------------------------------------
	assign analog_gt = analog_input_one_in > analog_input_two_in;

	genvar g;
	generate
		for (g = 0; g < NUM_TERMS; g++) begin : g_term
			term_select u_sel (
				.code_in      (sel_ff[g]),
				.status_in    (status_in),
				.analog_gt_in (analog_gt),
				.seq_pulse_in (pulse_cnt_ff != '0),
				.comm_bit_in  (comm_ff[g]),
				.level_out    (term_level[g])
			);
		end
	endgenerate

	always_comb begin
		nxt_term = term_level;
		if (rst_in) begin
			nxt_term = '0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		term_ff <= nxt_term;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata_out                       = prdata_ff;
	assign pready_out                       = pready_ff;
	assign pslverr_out                      = pslverr_ff;
	assign digital_output_one_out           = term_ff[TERM_DOUT_BIT];
	assign main_relay_contacts_out          = term_ff[TERM_RELAY1_BIT];
	assign second_relay_out                 = term_ff[TERM_RELAY2_BIT];
	assign open_collector_switch_output_out = term_ff[TERM_OCSW_BIT];

endmodule

// *** verif/out_term_monitor.sv ***
// Checker for the output terminal mux, watching the top module ports only.
`timescale 1ns/1ps
module out_term_monitor
	import out_term_pkg::*;
#(
	parameter int ANALOG_W     = 12,
	parameter int PULSE_CYCLES = SEQ_PULSE_CYCLES
) (
	// Clock, reset and bus
	input wire logic                sys_clk_in,
	input wire logic                rst_in,
	input wire logic                psel_in,
	input wire logic                penable_in,
	input wire logic                pwrite_in,
	input wire logic [7:0]          paddr_in,
	input wire logic [31:0]         pwdata_in,
	input wire logic                pready_out,
	input wire logic                pslverr_out,
	// Conditions and the watched terminal
	input wire drive_status_t       status_in,
	input wire logic [ANALOG_W-1:0] analog_input_one_in,
	input wire logic [ANALOG_W-1:0] analog_input_two_in,
	input wire logic                digital_output_one_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// Shadows of the first selector and its comm bit, loaded on the taken edge.
	logic [7:0]  sel_ff;
	logic [7:0]  nxt_sel;
	logic        comm_ff;
	logic        nxt_comm;
	logic [31:0] hi_ff;
	logic [31:0] nxt_hi;
	logic        taken;
	assign taken = psel_in & penable_in & ~pready_out & pwrite_in;
	always_comb begin
		nxt_sel = sel_ff;
		nxt_comm = comm_ff;
		nxt_hi = digital_output_one_out ? hi_ff + 32'h1 : 32'h0;
		if (taken && paddr_in == DIGITAL_OUT_ONE_FUNCTION_ADDR) begin
			nxt_sel = pwdata_in[7:0];
		end
		if (taken && paddr_in == COMM_VALUE_ADDR) begin
			nxt_comm = pwdata_in[0];
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sel_ff <= DIGITAL_OUT_RESET;
			comm_ff <= 1'b0;
			hi_ff <= 32'h0;
		end else begin
			sel_ff <= nxt_sel;
			comm_ff <= nxt_comm;
			hi_ff <= nxt_hi;
		end
	end

	a_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
		else $error("bus answer not a single pulse one cycle after the access");
	a_err_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("error flag seen without ready");
	a_zero_code_off: assert property (sel_ff == FN_NONE |=> !digital_output_one_out)
		else $error("code zero terminal not inactive");
	a_running_follow: assert property (sel_ff == FN_RUNNING |=>
		digital_output_one_out == $past(status_in.running))
		else $error("running code does not follow running state");
	a_fault_follow: assert property (sel_ff == FN_FAULT_STOP |=>
		digital_output_one_out == $past(status_in.fault_stopped))
		else $error("fault code does not follow fault stop");
	a_zero_run_gate: assert property (sel_ff == FN_ZERO_RUN |=>
		digital_output_one_out == $past(status_in.running & status_in.out_freq_zero))
		else $error("zero speed run code wrong");
	a_ready_for_run: assert property (sel_ff == FN_READY |=> digital_output_one_out ==
		$past(status_in.power_stable & ~status_in.fault_detected & status_in.operable))
		else $error("ready code wrong");
	a_analog_compare: assert property (sel_ff == FN_ANALOG_CMP |=>
		digital_output_one_out == $past(analog_input_one_in > analog_input_two_in))
		else $error("analog compare code wrong");
	a_comm_follow: assert property (sel_ff == FN_COMM |=>
		digital_output_one_out == $past(comm_ff))
		else $error("comm code does not follow written bit");
	a_reserved_off: assert property (sel_ff inside {8'h03, 8'h04, 8'h15, 8'h16} ||
		sel_ff > 8'h18 |=> !digital_output_one_out)
		else $error("undefined code terminal not inactive");
	a_pulse_width: assert property ($past(sel_ff, 2) == FN_SEQ_CYCLE && sel_ff == FN_SEQ_CYCLE &&
		$fell(digital_output_one_out) |-> hi_ff == PULSE_CYCLES)
		else $error("sequencer pulse width wrong");

	c_pulse: cover property (sel_ff == FN_SEQ_CYCLE && digital_output_one_out);
	c_error: cover property (pready_out && pslverr_out);
	c_comm: cover property (sel_ff == FN_COMM && digital_output_one_out);
endmodule

bind output_terminal_function_mux out_term_monitor #(
	.ANALOG_W(ANALOG_W),
	.PULSE_CYCLES(PULSE_CYCLES)
) u_monitor (
	.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
	.pready_out, .pslverr_out, .status_in, .analog_input_one_in, .analog_input_two_in,
	.digital_output_one_out
);

// *** verif/field_wiring_model.sv ***
// Model of the field loads wired to the four switched terminals.
`timescale 1ns/1ps
module field_wiring_model (
	// Terminals from the drive
	input  wire logic dout_in,
	input  wire logic relay_one_in,
	input  wire logic relay_two_in,
	input  wire logic open_coll_in,
	// Load states
	output logic [3:0] load_on_out
);
	// Passive loads: each is energised exactly while its terminal is ON, nothing latches.
	assign load_on_out = {open_coll_in, relay_two_in, relay_one_in, dout_in};
endmodule

// *** verif/output_terminal_function_mux_tb_top.sv ***
// Self-checking testbench for the output terminal function mux.
`timescale 1ns/1ps
module output_terminal_function_mux_tb_top;
	import out_term_pkg::*;
	localparam int          P_CYC = 20;
	localparam logic [32:0] RD_M  = {33{1'b1}};
	localparam logic [32:0] WR_M  = {1'b1, 32'h0};
	localparam logic [7:0]  SEL_A [4] = '{DIGITAL_OUT_ONE_FUNCTION_ADDR, MAIN_RELAY_FUNCTION_ADDR,
		SECOND_RELAY_FUNCTION_ADDR, OPEN_COLLECTOR_SWITCH_FUNCTION_ADDR};
	typedef struct {logic [32:0] e; logic [32:0] m; string n;} note_t;
	logic          sys_clk_in = 1'b0;
	logic          rst_in = 1'b1;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic          probe = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	drive_status_t status_r = '0;
	logic [11:0]   an1 = 12'h000;
	logic [11:0]   an2 = 12'h000;
	wire [3:0]     terms;
	logic [3:0]    loads;
	note_t         note_q[$];
	int            n_fail = 0;
	int            n_compared = 0;

	initial forever #2.5 sys_clk_in = ~sys_clk_in;

	output_terminal_function_mux #(.ANALOG_W(12), .PULSE_CYCLES(P_CYC)) DUT (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .status_in(status_r),
		.analog_input_one_in(an1), .analog_input_two_in(an2),
		.digital_output_one_out(terms[0]), .main_relay_contacts_out(terms[1]),
		.second_relay_out(terms[2]), .open_collector_switch_output_out(terms[3]));
	field_wiring_model loads_model (.dout_in(terms[0]), .relay_one_in(terms[1]),
		.relay_two_in(terms[2]), .open_coll_in(terms[3]), .load_on_out(loads));

	task automatic close_out();
		// A note still waiting here is an answer that never came.
		if (note_q.size() != 0) begin
			n_fail++;
		end
		$display("Counts: compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Oldest note is matched against each bus answer or terminal probe.
	always @(posedge sys_clk_in) begin
		logic [32:0] got;
		if (pready === 1'b1 || probe) begin
			got = probe ? {29'h0, loads} : {pslverr, prdata};
			n_compared++;
			if (note_q.size() == 0) begin
				n_fail++;
				$display("ERROR unexpected result expected none seen %h", got);
			end else if (((got ^ note_q[0].e) & note_q[0].m) !== 33'h0) begin
				n_fail++;
				$display("ERROR %s expected %h seen %h", note_q[0].n, note_q[0].e, got);
			end
			if (note_q.size() > 0) void'(note_q.pop_front());
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		int k;
		note_q.push_back('{e, m, $sformatf("bus access %h", a)});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk_in);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_fail++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps the next call from driving psel twice in one step.
		@(posedge sys_clk_in);
	endtask

	task automatic check_terms(input logic [3:0] e);
		repeat (2) @(posedge sys_clk_in);
		note_q.push_back('{{29'h0, e}, {29'h0, 4'hf}, "terminals"});
		probe <= 1'b1;
		@(posedge sys_clk_in);
		probe <= 1'b0;
	endtask

	function automatic logic exp_level(logic [7:0] c, drive_status_t s, logic agt, logic cb);
		case (c)
			8'h01: return s.running;
			8'h02: return s.fault_stopped;
			8'h05: return s.running & s.out_freq_zero;
			8'h06: return s.motor_ol_prealarm;
			8'h07: return s.drive_ol_prealarm;
			8'h08: return s.set_count_reached;
			8'h09: return s.desig_count_reached;
			8'h0a: return s.length_reached;
			8'h0c: return s.run_time_reached;
			8'h0d: return s.set_freq_beyond_limit & (s.at_upper_limit | s.at_lower_limit);
			8'h0e: return s.torque_at_limit & s.stall_active;
			8'h0f: return s.power_stable & ~s.fault_detected & s.operable;
			8'h10: return agt;
			8'h11: return s.running & s.at_upper_limit;
			8'h12: return s.running & s.at_lower_limit;
			8'h13: return s.undervoltage;
			8'h14: return cb;
			8'h17: return s.out_freq_zero | ~s.running;
			8'h18: return s.power_on_time_reached;
			default: return 1'b0;
		endcase
	endfunction

	initial begin
		drive_status_t s;
		logic [3:0]    cb;
		logic [3:0]    e;
		logic [11:0]   a1;
		logic [11:0]   a2;
		void'($urandom(32'h97073f53));
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		apb(1'b0, SEL_A[0], 32'h0, {25'h0, DIGITAL_OUT_RESET}, RD_M);
		apb(1'b0, SEL_A[1], 32'h0, {25'h0, MAIN_RELAY_RESET}, RD_M);
		apb(1'b0, SEL_A[2], 32'h0, {25'h0, SECOND_RELAY_RESET}, RD_M);
		apb(1'b0, SEL_A[3], 32'h0, {25'h0, OPEN_COLL_RESET}, RD_M);
		apb(1'b1, RESERVED_OUTPUT_SLOT_ADDR, 32'hff, 33'h0, WR_M);
		apb(1'b0, RESERVED_OUTPUT_SLOT_ADDR, 32'h0, 33'h0, RD_M);
		apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0}, RD_M);
		apb(1'b1, TERMINAL_STATUS_ADDR, 32'hf, {1'b1, 32'h0}, WR_M);
		s = drive_status_t'($urandom);
		status_r <= s;
		check_terms({2'b00, s.fault_stopped, s.running});
		apb(1'b0, TERMINAL_STATUS_ADDR, 32'h0, {29'h0, 2'b00, s.fault_stopped, s.running}, RD_M);
		$display("Test reset and register map done");
		for (int c = 0; c < 27; c++) begin
			cb = 4'($urandom);
			apb(1'b1, COMM_VALUE_ADDR, {28'h0, cb}, 33'h0, WR_M);
			apb(1'b0, COMM_VALUE_ADDR, 32'h0, {29'h0, cb}, RD_M);
			for (int t = 0; t < 4; t++) begin
				apb(1'b1, SEL_A[t], {24'($urandom), 8'(c)}, 33'h0, WR_M);
			end
			apb(1'b0, SEL_A[0], 32'h0, {25'h0, 8'(c)}, RD_M);
			for (int k = 0; k < 4; k++) begin
				s = drive_status_t'($urandom);
				s.seq_cycle_done = 1'b0;
				a1 = 12'($urandom);
				a2 = (k == 0) ? a1 : 12'($urandom);
				status_r <= s;
				an1 <= a1;
				an2 <= a2;
				for (int t = 0; t < 4; t++) e[t] = exp_level(8'(c), s, a1 > a2, cb[t]);
				check_terms(e); // to to
			end
		end
		$display("Test function code sweep done");
		for (int t = 0; t < 4; t++) apb(1'b1, SEL_A[t], 32'h0b, 33'h0, WR_M);
		s.seq_cycle_done = 1'b1;
		status_r <= s;
		check_terms(4'hf);
		repeat (P_CYC - 8) @(posedge sys_clk_in);
		check_terms(4'hf);
		repeat (6) @(posedge sys_clk_in);
		check_terms(4'h0);
		$display("Test sequencer pulse done");
		repeat (2) @(posedge sys_clk_in);
		close_out();
	end
endmodule
